// >>> verilog/bsm_top.sv
/*
 * Boundary scan mode control: strap and fuse decode, test access port,
 * boundary scan chain over the device pins and a Wishbone register slave.
 * Assumes straps, test port pins and pin levels are asynchronous, fuse
 * shadow bits and the debug logic output are on the system clock.
 */
// Added by the designer: the register offsets and the Wishbone register port.
// Contract
// - The port-select strap routes the test port to core debug at 0 and to the boundary scan chain at 1.
// - Scan operation depends on the factory test strap, the power-on reset pin, the port-select strap and the fuses; the code ignores the fuses for scan.
// - Boot-source strap 00 boots from fuses, 01 enters the serial downloader and 10 selects internal boot.
// - Debug security fuses 00 give open debug access and 01 give secure debug.
// - The debug controller stays enabled only while its kill fuse reads 0.
// - The pin cells form one serial shift chain that can capture pin levels or drive pins.
// - Every chain pin is input-only, tri-state output, two-state output, bidirectional or linkage.
// - Linkage pins get no scan cell and can be neither driven nor captured.
// - Serial lane pins carry cells for the AC-coupled test extension.
`timescale 1ns/1ps
module bsm_top
   import bsm_pkg::*;
#(
   parameter int                    NPIN      = BSM_NPIN,
   parameter logic [3*NPIN-1:0]     PIN_CLASS = BSM_PIN_CLASS_DFLT,
   parameter logic [NPIN-1:0]       PIN_AC    = BSM_PIN_AC_DFLT
) (
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire bsm_strap_t          strap,
   input  wire bsm_fuse_t           fuse,
   input  wire bsm_tap_in_t         tap_in,
   output logic                     tdo,
   output logic                     tdo_oe_n,
   output bsm_tap_in_t              dbg_tap,
   input  wire logic                dbg_tdo,
   output logic                     dbg_port_sel,
   output logic                     dbg_secure,
   output logic                     dbg_ctrl_en,
   output bsm_boot_t                boot_mode,
   output logic                     scan_mode,
   input  wire logic [NPIN-1:0]     pin_in,
   output logic      [NPIN-1:0]     pin_out,
   output logic      [NPIN-1:0]     pin_oe_n,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic      [31:0]         wb_dat_o,
   output logic                     wb_ack_o
);
   function automatic int cells_of(logic [2:0] cls);
      int n;
      n = 0;
      if (cls == BSM_PC_IN || cls == BSM_PC_BUF) n = 1;
      if (cls == BSM_PC_OUT || cls == BSM_PC_INOUT) n = 2;
      return n;
   endfunction

   function automatic int off_of(int pin);
      int sum;
      sum = 0;
      for (int k = 0; k < pin; k++) sum += cells_of(PIN_CLASS[3*k +: 3]);
      return sum;
   endfunction

   localparam int CHAIN = off_of(NPIN);
   localparam int CL    = (CHAIN > 0) ? CHAIN : 1;

   typedef struct packed {
      bsm_tap_t      tap;
      logic [3:0]    ir_sh;
      logic [3:0]    ir;
      logic [CL-1:0] dr;
      logic [CL-1:0] upd;
      logic          byp;
      logic          tck_prev;
      logic          ac_ph;
      logic          por_prev;
      logic [NPIN-1:0] pin_out;
      logic [NPIN-1:0] pin_oe_n;
      logic          tdo;
      logic          tdo_oe_n;
      bsm_tap_in_t   dbg_tap;
      logic          dbg_sel;
      logic          dbg_secure;
      logic          dbg_ctrl_en;
      bsm_dbg_t      dbg;
      bsm_boot_t     boot;
      logic          scan;
      logic [NPIN-1:0] func_out;
      logic [NPIN-1:0] func_oe;
      logic          ack;
      logic [31:0]   rdat;
   } bsm_st_t;

   bsm_st_t s_q;
   bsm_st_t s_d;

   logic [5+3+NPIN-1:0] sync_q;
   bsm_strap_t          strap_s;
   bsm_tap_in_t         tap_s;
   logic [NPIN-1:0]     pin_lvl;
   logic [CL-1:0]       cap;
   logic [NPIN-1:0]     ext_val;
   logic [NPIN-1:0]     ext_en;
   logic [NPIN-1:0]     drv_ok;

   // Every pin-side level passes two flops before anything looks at it.
   bsm_sync2 #(.W(5+3+NPIN)) u_sync (
      .clock (clock),
      .rst   (rst),
      .d     ({strap, tap_in, pin_in}),
      .q     (sync_q)
   );
   assign strap_s = sync_q[5+3+NPIN-1 -: 5];
   assign tap_s   = sync_q[3+NPIN-1 -: 3];
   assign pin_lvl = sync_q[NPIN-1:0];

   if (CHAIN == 0) begin : g_nochain
      assign cap = '0;
   end
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      localparam int         O = off_of(i);
      localparam logic [2:0] C = PIN_CLASS[3*i +: 3];
      if (C == BSM_PC_IN) begin : g_in
         assign cap[O]     = pin_lvl[i];
         assign ext_val[i] = 1'b0;
         assign ext_en[i]  = 1'b0;
         assign drv_ok[i]  = 1'b0;
      end else if (C == BSM_PC_OUT || C == BSM_PC_INOUT) begin : g_tri
         // Bidirectional cells read the pad, pure outputs read back what they drive.
         assign cap[O]     = (C == BSM_PC_INOUT) ? pin_lvl[i] : s_q.pin_out[i];
         assign cap[O+1]   = ~s_q.pin_oe_n[i];
         assign ext_val[i] = s_q.upd[O];
         assign ext_en[i]  = s_q.upd[O+1];
         assign drv_ok[i]  = 1'b1;
      end else if (C == BSM_PC_BUF) begin : g_buf
         assign cap[O]     = s_q.pin_out[i];
         assign ext_val[i] = s_q.upd[O];
         assign ext_en[i]  = 1'b1;
         assign drv_ok[i]  = 1'b1;
      end else begin : g_link
         assign ext_val[i] = 1'b0;
         assign ext_en[i]  = 1'b0;
         assign drv_ok[i]  = 1'b0;
      end
   end

   function automatic bsm_tap_t tap_next(bsm_tap_t st, logic tms);
      bsm_tap_t n;
      n = st;
      unique case (st)
         BSM_TAP_RESET:    n = tms ? BSM_TAP_RESET   : BSM_TAP_IDLE;
         BSM_TAP_IDLE:     n = tms ? BSM_TAP_SEL_DR  : BSM_TAP_IDLE;
         BSM_TAP_SEL_DR:   n = tms ? BSM_TAP_SEL_IR  : BSM_TAP_CAP_DR;
         BSM_TAP_CAP_DR:   n = tms ? BSM_TAP_EX1_DR  : BSM_TAP_SH_DR;
         BSM_TAP_SH_DR:    n = tms ? BSM_TAP_EX1_DR  : BSM_TAP_SH_DR;
         BSM_TAP_EX1_DR:   n = tms ? BSM_TAP_UPD_DR  : BSM_TAP_PAUSE_DR;
         BSM_TAP_PAUSE_DR: n = tms ? BSM_TAP_EX2_DR  : BSM_TAP_PAUSE_DR;
         BSM_TAP_EX2_DR:   n = tms ? BSM_TAP_UPD_DR  : BSM_TAP_SH_DR;
         BSM_TAP_UPD_DR:   n = tms ? BSM_TAP_SEL_DR  : BSM_TAP_IDLE;
         BSM_TAP_SEL_IR:   n = tms ? BSM_TAP_RESET   : BSM_TAP_CAP_IR;
         BSM_TAP_CAP_IR:   n = tms ? BSM_TAP_EX1_IR  : BSM_TAP_SH_IR;
         BSM_TAP_SH_IR:    n = tms ? BSM_TAP_EX1_IR  : BSM_TAP_SH_IR;
         BSM_TAP_EX1_IR:   n = tms ? BSM_TAP_UPD_IR  : BSM_TAP_PAUSE_IR;
         BSM_TAP_PAUSE_IR: n = tms ? BSM_TAP_EX2_IR  : BSM_TAP_PAUSE_IR;
         BSM_TAP_EX2_IR:   n = tms ? BSM_TAP_UPD_IR  : BSM_TAP_SH_IR;
         BSM_TAP_UPD_IR:   n = tms ? BSM_TAP_SEL_DR  : BSM_TAP_IDLE;
      endcase
      return n;
   endfunction

   function automatic logic [NPIN-1:0] lane_write(logic [NPIN-1:0] old, logic [31:0] wd, logic [3:0] sel);
      logic [31:0] v;
      v = 32'(old);
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) v[8*b +: 8] = wd[8*b +: 8];
      end
      return v[NPIN-1:0];
   endfunction

   logic tck_rise;
   logic tck_fall;
   logic chain_sel;
   logic ext_on;
   logic wb_req;
   logic [5:0] wb_word;
   always_comb begin
      s_d = s_q;
      tck_rise = tap_s.tck & ~s_q.tck_prev;
      tck_fall = ~tap_s.tck & s_q.tck_prev;
      chain_sel = (s_q.ir == BSM_IR_EXTEST) || (s_q.ir == BSM_IR_SAMPLE) || (s_q.ir == BSM_IR_AC_PULSE);
      ext_on = s_q.scan && ((s_q.ir == BSM_IR_EXTEST) || (s_q.ir == BSM_IR_AC_PULSE));
      wb_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
      wb_word = wb_adr_i[7:2];
      s_d.tck_prev = tap_s.tck;
      s_d.por_prev = strap_s.por_n;

      // Scan needs reset released, port select high and factory test low.
      s_d.scan = strap_s.por_n & strap_s.test_port_select & ~strap_s.factory_test;
      unique case (fuse.debug_security_level)
         2'b00:   s_d.dbg = BSM_DBG_OPEN;
         2'b01:   s_d.dbg = BSM_DBG_SECURE;
         default: s_d.dbg = BSM_DBG_LOCKED;
      endcase
      s_d.dbg_ctrl_en = ~fuse.debug_controller_kill;
      s_d.dbg_secure = (s_q.dbg == BSM_DBG_SECURE);
      s_d.dbg_sel = strap_s.por_n & ~strap_s.test_port_select & ~strap_s.factory_test
                    & (s_q.dbg != BSM_DBG_LOCKED);
      s_d.dbg_tap = s_q.dbg_sel ? tap_s : '0;

      // Boot straps follow the pins while reset is held and freeze at its release.
      if (!strap_s.por_n || !s_q.por_prev) begin
         unique case (strap_s.boot_source)
            2'b00: s_d.boot = BSM_BOOT_FUSES;
            2'b01: s_d.boot = BSM_BOOT_SERIAL;
            2'b10: s_d.boot = BSM_BOOT_INTERNAL;
            2'b11: s_d.boot = BSM_BOOT_RESERVED;
         endcase
      end

      if (!s_q.scan) begin
         s_d.tap = BSM_TAP_RESET;
         s_d.ir = BSM_IR_BYPASS;
         s_d.ac_ph = 1'b0;
      end else if (tck_rise) begin
         unique case (s_q.tap)
            BSM_TAP_CAP_DR: begin
               if (chain_sel) s_d.dr = cap;
               s_d.byp = 1'b0;
            end
            BSM_TAP_SH_DR: begin
               if (CHAIN > 1) s_d.dr = {tap_s.tdi, s_q.dr[CL-1:1]};
               else s_d.dr = CL'(tap_s.tdi);
               s_d.byp = tap_s.tdi;
            end
            BSM_TAP_CAP_IR: s_d.ir_sh = BSM_IR_CAPTURE;
            BSM_TAP_SH_IR:  s_d.ir_sh = {tap_s.tdi, s_q.ir_sh[3:1]};
            default: ;
         endcase
         s_d.tap = tap_next(s_q.tap, tap_s.tms);
         // The AC pulse instruction toggles lane drive on every test clock in idle.
         s_d.ac_ph = (s_q.ir == BSM_IR_AC_PULSE) && (s_q.tap == BSM_TAP_IDLE) && !s_q.ac_ph;
      end else if (tck_fall) begin
         unique case (s_q.tap)
            BSM_TAP_UPD_DR: if (chain_sel) s_d.upd = s_q.dr;
            BSM_TAP_UPD_IR: s_d.ir = s_q.ir_sh;
            BSM_TAP_RESET:  s_d.ir = BSM_IR_BYPASS;
            default: ;
         endcase
      end

      // In scan mode test data out changes on the falling test clock and floats outside shifts; with debug routed it always drives dbg_tdo.
      if (s_q.dbg_sel) begin
         s_d.tdo = dbg_tdo;
         s_d.tdo_oe_n = 1'b0;
      end else if (!s_q.scan) begin
         s_d.tdo = 1'b0;
         s_d.tdo_oe_n = 1'b1;
      end else if (tck_fall) begin
         s_d.tdo_oe_n = !((s_q.tap == BSM_TAP_SH_DR) || (s_q.tap == BSM_TAP_SH_IR));
         if (s_q.tap == BSM_TAP_SH_IR) s_d.tdo = s_q.ir_sh[0];
         else if (chain_sel) s_d.tdo = s_q.dr[0];
         else s_d.tdo = s_q.byp;
      end

      for (int i = 0; i < NPIN; i++) begin
         if (ext_on) begin
            s_d.pin_out[i] = ext_val[i] ^ (s_q.ac_ph & PIN_AC[i]);
            s_d.pin_oe_n[i] = ~ext_en[i];
         end else begin
            s_d.pin_out[i] = s_q.func_out[i];
            s_d.pin_oe_n[i] = ~(s_q.func_oe[i] & drv_ok[i]);
         end
      end

      // Single-wait-state slave: ack in the cycle after the request is seen.
      s_d.ack = wb_req;
      s_d.rdat = 32'h00000000;
      if (wb_req && wb_we_i) begin
         if (wb_word == BSM_REG_FUNC_OUT[7:2]) s_d.func_out = lane_write(s_q.func_out, wb_dat_i, wb_sel_i);
         if (wb_word == BSM_REG_FUNC_OE[7:2])  s_d.func_oe  = lane_write(s_q.func_oe, wb_dat_i, wb_sel_i);
      end else if (wb_req) begin
         if (wb_word == BSM_REG_MODE[7:2]) begin
            s_d.rdat = {15'h0000, 4'(s_q.tap), s_q.ir, s_q.dbg_ctrl_en, 2'(s_q.dbg), 2'(s_q.boot),
                        strap_s.factory_test, strap_s.test_port_select, strap_s.por_n, s_q.scan};
         end
         if (wb_word == BSM_REG_FUNC_OUT[7:2])  s_d.rdat = 32'(s_q.func_out);
         if (wb_word == BSM_REG_FUNC_OE[7:2])   s_d.rdat = 32'(s_q.func_oe);
         if (wb_word == BSM_REG_PIN_LEVEL[7:2]) s_d.rdat = 32'(pin_lvl);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_q          <= '0;
         s_q.ir       <= BSM_IR_BYPASS;
         s_q.pin_oe_n <= '1;
         s_q.tdo_oe_n <= 1'b1;
         s_q.dbg      <= BSM_DBG_LOCKED;
         s_q.func_out <= BSM_FUNC_OUT_RST[NPIN-1:0];
         s_q.func_oe  <= BSM_FUNC_OE_RST[NPIN-1:0];
      end else begin
         s_q <= s_d;
      end
   end

   assign tdo          = s_q.tdo;
   assign tdo_oe_n     = s_q.tdo_oe_n;
   assign dbg_tap      = s_q.dbg_tap;
   assign dbg_port_sel = s_q.dbg_sel;
   assign dbg_secure   = s_q.dbg_secure;
   assign dbg_ctrl_en  = s_q.dbg_ctrl_en;
   assign boot_mode    = s_q.boot;
   assign scan_mode    = s_q.scan;
   assign pin_out      = s_q.pin_out;
   assign pin_oe_n     = s_q.pin_oe_n;
   assign wb_dat_o     = s_q.rdat;
   assign wb_ack_o     = s_q.ack;
endmodule // bsm_top

// >>> verilog/bsm_pkg.sv
/*
 * Shared constants and types for the boundary scan mode control block:
 * register map, test port instruction codes, pin classes, strap and fuse
 * carriers and the state encodings.
 * Assumes a 32-bit classic Wishbone register bus and a 4-bit instruction register.
 */
package bsm_pkg;

   localparam int BSM_NPIN = 16;
   localparam int BSM_IR_W = 4;

   // Instruction codes; any code not listed behaves as bypass.
   localparam logic [3:0] BSM_IR_EXTEST   = 4'h0;
   localparam logic [3:0] BSM_IR_SAMPLE   = 4'h1;
   localparam logic [3:0] BSM_IR_AC_PULSE = 4'h4;
   localparam logic [3:0] BSM_IR_BYPASS   = 4'hF;
   localparam logic [3:0] BSM_IR_CAPTURE  = 4'h1;

   // Pin classes, three bits per pin.
   localparam logic [2:0] BSM_PC_IN    = 3'h0;
   localparam logic [2:0] BSM_PC_OUT   = 3'h1;
   localparam logic [2:0] BSM_PC_BUF   = 3'h2;
   localparam logic [2:0] BSM_PC_INOUT = 3'h3;
   localparam logic [2:0] BSM_PC_LINK  = 3'h4;

   // Pin 0 sits in the low bits; pins 14 and 15 are the serial lane outputs.
   localparam logic [3*BSM_NPIN-1:0] BSM_PIN_CLASS_DFLT = {
      BSM_PC_BUF, BSM_PC_BUF, BSM_PC_LINK, BSM_PC_INOUT, BSM_PC_INOUT, BSM_PC_INOUT,
      BSM_PC_OUT, BSM_PC_OUT, BSM_PC_OUT, BSM_PC_BUF, BSM_PC_IN, BSM_PC_IN,
      BSM_PC_IN, BSM_PC_IN, BSM_PC_LINK, BSM_PC_IN};
   localparam logic [BSM_NPIN-1:0] BSM_PIN_AC_DFLT = 16'hC000;

   // Register byte offsets.
   localparam logic [7:0] BSM_REG_MODE      = 8'h00;
   localparam logic [7:0] BSM_REG_FUNC_OUT  = 8'h04;
   localparam logic [7:0] BSM_REG_FUNC_OE   = 8'h08;
   localparam logic [7:0] BSM_REG_PIN_LEVEL = 8'h0C;
   localparam logic [31:0] BSM_FUNC_OUT_RST = 32'h00000000;
   localparam logic [31:0] BSM_FUNC_OE_RST  = 32'h00000000;

   typedef struct packed {
      logic       factory_test;
      logic       por_n;
      logic       test_port_select;
      logic [1:0] boot_source;
   } bsm_strap_t;

   typedef struct packed {
      logic [1:0] debug_security_level;
      logic       debug_controller_kill;
   } bsm_fuse_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bsm_tap_in_t;

   typedef enum logic [1:0] {BSM_BOOT_FUSES, BSM_BOOT_SERIAL, BSM_BOOT_INTERNAL, BSM_BOOT_RESERVED} bsm_boot_t;
   typedef enum logic [1:0] {BSM_DBG_OPEN, BSM_DBG_SECURE, BSM_DBG_LOCKED} bsm_dbg_t;

   typedef enum logic [3:0] {
      BSM_TAP_RESET, BSM_TAP_IDLE, BSM_TAP_SEL_DR, BSM_TAP_CAP_DR, BSM_TAP_SH_DR, BSM_TAP_EX1_DR,
      BSM_TAP_PAUSE_DR, BSM_TAP_EX2_DR, BSM_TAP_UPD_DR, BSM_TAP_SEL_IR, BSM_TAP_CAP_IR,
      BSM_TAP_SH_IR, BSM_TAP_EX1_IR, BSM_TAP_PAUSE_IR, BSM_TAP_EX2_IR, BSM_TAP_UPD_IR
   } bsm_tap_t;

endpackage

// >>> verilog/bsm_sync2.sv
/*
 * Two-stage synchroniser for a bundle of asynchronous levels.
 * Assumes each bit is an independent level; no word coherency is given.
 */
`timescale 1ns/1ps
module bsm_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } bsm_sync_st_t;

   bsm_sync_st_t s_q;
   bsm_sync_st_t s_d;

   always_comb begin
      s_d.meta   = d;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stable;
endmodule // bsm_sync2

// >>> sim/bsm_tester.sv
/*
 * Board tester model: drives tck, tms and tdi of the test port and samples tdo.
 * Assumes a 25 MHz system clock; tck runs at 320 ns only while a step is in progress.
 */
`timescale 1ns/1ps
module bsm_tester
   import bsm_pkg::*;
(
   input  wire logic  clock,
   input  wire logic  tdo,
   input  wire logic  tdo_oe_n,
   output bsm_tap_in_t tap
);
   initial begin
      tap = '0;
   end
   // Five clocks low and three high; the long low phase lets the synchronised tdo settle before it is sampled.
   task automatic step(input logic ms, input logic di, output logic db);
      @(posedge clock);
      tap.tms <= ms;
      tap.tdi <= di;
      repeat (4) @(posedge clock);
      db = tdo_oe_n ? 1'b1 : tdo;
      tap.tck <= 1'b1;
      repeat (3) @(posedge clock);
      tap.tck <= 1'b0;
   endtask
endmodule  // bsm_tester

// >>> sim/bsm_sva.sv
/*
 * Checker for bsm_top: bus answers, strap and fuse decode, pin drive limits.
 * Assumes straps and fuses hold still a few clocks before their decode is judged.
 */
`timescale 1ns/1ps
module bsm_sva
   import bsm_pkg::*;
#(
   parameter int                NPIN      = BSM_NPIN,
   parameter logic [3*NPIN-1:0] PIN_CLASS = BSM_PIN_CLASS_DFLT
) (
   input wire logic            clock,
   input wire logic            rst,
   input wire bsm_strap_t      strap,
   input wire bsm_fuse_t       fuse,
   input wire logic            dbg_port_sel,
   input wire logic            dbg_secure,
   input wire logic            dbg_ctrl_en,
   input wire bsm_boot_t       boot_mode,
   input wire logic            scan_mode,
   input wire logic [NPIN-1:0] pin_oe_n,
   input wire logic            wb_cyc_i,
   input wire logic            wb_stb_i,
   input wire logic            wb_ack_o
);
   function automatic logic [NPIN-1:0] undriven();
      for (int p = 0; p < NPIN; p++) begin
         undriven[p] = PIN_CLASS[3*p +: 3] == BSM_PC_IN || PIN_CLASS[3*p +: 3] == BSM_PC_LINK;
      end
   endfunction
   localparam logic [NPIN-1:0] NODRV = undriven();
   logic [7:0] prev_q;
   logic [3:0] quiet_q;
   logic       settled;
   // Straps pass a synchroniser, so decode is only judged after six quiet clocks.
   always_ff @(posedge clock) begin
      prev_q <= {strap, fuse};
      quiet_q <= (rst || {strap, fuse} != prev_q) ? 4'h0 : quiet_q + 4'(quiet_q != 4'hF);
   end
   // A change in the current cycle clears it at once, before the counter has seen it.
   assign settled = quiet_q >= 4'h6 && {strap, fuse} == prev_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   ack_answer_a: assert property (s_req |=> s_ack)
      else $error("bus request not answered by a one-cycle ack");
   scan_decode_a: assert property (settled |-> scan_mode == (strap.por_n && strap.test_port_select && !strap.factory_test))
      else $error("scan mode does not follow straps");
   scan_excl_a: assert property (scan_mode |-> !dbg_port_sel)
      else $error("scan and debug routing both active");
   debug_route_a: assert property (settled |-> dbg_port_sel == (strap.por_n && !strap.test_port_select
                                   && !strap.factory_test && !fuse.debug_security_level[1]))
      else $error("debug routing does not follow straps");
   fuse_secure_a: assert property (settled |-> dbg_secure == (fuse.debug_security_level == 2'h1))
      else $error("secure debug decode wrong");
   kill_enable_a: assert property (settled |-> dbg_ctrl_en == !fuse.debug_controller_kill)
      else $error("debug controller enable wrong");
   boot_track_a: assert property (settled && !strap.por_n |-> boot_mode == strap.boot_source)
      else $error("boot mode does not follow strap");
   pin_nodrive_a: assert property ((pin_oe_n & NODRV) == NODRV)
      else $error("input or linkage pin driven");
endmodule  // bsm_sva
bind bsm_top bsm_sva #(.NPIN(NPIN), .PIN_CLASS(PIN_CLASS)) u_sva (.clock(clock), .rst(rst), .strap(strap),
   .fuse(fuse), .dbg_port_sel(dbg_port_sel), .dbg_secure(dbg_secure), .dbg_ctrl_en(dbg_ctrl_en),
   .boot_mode(boot_mode), .scan_mode(scan_mode), .pin_oe_n(pin_oe_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// >>> sim/testbench.sv
/*
 * Self-checking bench for bsm_top: straps, fuses, registers and the scan chain.
 * Assumes bsm_tester works the test port and the default pin map of the package.
 */
`timescale 1ns/1ps
module testbench;
   import bsm_pkg::*;
   logic        clock, rst, tdo, tdo_oe_n, dbg_port_sel, dbg_secure, dbg_ctrl_en, scan_mode, dbg_tdo;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]  wb_sel_i;
   logic [7:0]  wb_adr_i;
   logic [15:0] pin_in, pin_out, pin_oe_n, ac;
   logic [31:0] wb_dat_i, wb_dat_o, rd, sv;
   bsm_strap_t  strap;
   bsm_fuse_t   fuse;
   bsm_tap_in_t tap_in, dbg_tap;
   bsm_boot_t   boot_mode;
   int          failures, samples_checked;
   // Driven pins, bidirectional plus three-state pins, and two-state pins of the default map.
   localparam logic [15:0] DRV = 16'hDFC0, OIO = 16'h1F80, BUFM = 16'hC040;
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   bsm_top u_dut (.clock(clock), .rst(rst), .strap(strap), .fuse(fuse), .tap_in(tap_in), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .dbg_tap(dbg_tap), .dbg_tdo(dbg_tdo), .dbg_port_sel(dbg_port_sel),
      .dbg_secure(dbg_secure), .dbg_ctrl_en(dbg_ctrl_en), .boot_mode(boot_mode), .scan_mode(scan_mode),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   bsm_tester u_tst (.clock(clock), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tap(tap_in));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do @(posedge clock); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic tms_seq(input logic [7:0] m, input int n);
      logic b;
      for (int i = 0; i < n; i++) u_tst.step(m[i], 1'b0, b);
   endtask
   // Shifts sv out LSB first with tms high on the last bit; captured bits replace sent ones.
   task automatic shift(input int n);
      logic b;
      for (int i = 0; i < n; i++) begin
         u_tst.step(i == n - 1, sv[i], b);
         sv[i] = b;
      end
   endtask
   task automatic ir(input logic [3:0] c);
      sv = {28'h0, c};
      tms_seq(8'h03, 4);
      shift(4);
      tms_seq(8'h01, 2);
   endtask
   task automatic dr(input logic [31:0] d);
      sv = d;
      tms_seq(8'h01, 3);
      shift(20);
      tms_seq(8'h01, 2);
      repeat (6) @(posedge clock);
   endtask
   // Chain image for pad levels pi, output data o and enables e; bit 20 is scratch.
   function automatic logic [31:0] cap(input logic [15:0] pi, o, e);
      int k;
      logic [2:0] c;
      cap = '0;
      k = 0;
      for (int p = 0; p < BSM_NPIN; p++) begin
         c = BSM_PIN_CLASS_DFLT[3*p +: 3];
         cap[k] = (c == BSM_PC_OUT || c == BSM_PC_BUF) ? o[p] : pi[p];
         k += int'(c != BSM_PC_LINK);
         cap[k] = e[p];
         k += int'(c == BSM_PC_OUT || c == BSM_PC_INOUT);
      end
   endfunction
   task automatic summarize();
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      strap = '0;
      fuse = '0;
      pin_in = 16'h5A3C;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, dbg_tdo} = '0;
      failures = 0;
      samples_checked = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (int b = 0; b < 4; b++) begin
         strap.boot_source <= b[1:0];
         repeat (8) @(posedge clock);
         chk("boot_mode", b, boot_mode);
      end
      strap.por_n <= 1'b1;
      repeat (6) @(posedge clock);
      strap.boot_source <= 2'h1;
      repeat (6) @(posedge clock);
      chk("boot_frozen", 3, boot_mode);
      for (int f = 0; f < 8; f++) begin
         fuse <= f[2:0];
         repeat (8) @(posedge clock);
         chk("dbg_secure", f[2:1] == 2'h1, dbg_secure);
         chk("dbg_ctrl_en", !f[0], dbg_ctrl_en);
         chk("dbg_port_sel", !f[2], dbg_port_sel);
      end
      fuse <= 3'h0;
      // With debug routed, the port pins reach the debug logic and its data out drives tdo.
      dbg_tdo <= 1'b1;
      tms_seq(8'h01, 1);
      repeat (6) @(posedge clock);
      chk("dbg_tap", 3'h2, dbg_tap);
      chk("dbg_tdo", 2'h2, {tdo, tdo_oe_n});
      wb(1'b1, BSM_REG_FUNC_OUT, 4'hF, 32'hFFFFA5C3);
      wb(1'b0, BSM_REG_FUNC_OUT, 4'hF, '0);
      chk("func_out", 32'h0000A5C3, rd);
      wb(1'b1, BSM_REG_FUNC_OE, 4'h2, 32'hFFFF0F0F);
      wb(1'b0, BSM_REG_FUNC_OE, 4'hF, '0);
      chk("func_oe", 32'h00000F00, rd);
      wb(1'b1, BSM_REG_FUNC_OE, 4'h1, 32'h0000000F);
      wb(1'b1, 8'h40, 4'hF, 32'hFFFFFFFF);
      wb(1'b0, 8'h40, 4'hF, '0);
      chk("unmapped", 32'h0, rd);
      wb(1'b0, BSM_REG_PIN_LEVEL, 4'hF, '0);
      chk("pin_level", 32'h00005A3C, rd);
      wb(1'b0, BSM_REG_MODE, 4'hF, '0);
      chk("mode", 32'h00001F32, rd);
      chk("pin_out", 16'hA5C3 & DRV, pin_out & DRV);
      chk("pin_oe_n", 16'(~(16'h0F0F & DRV)), pin_oe_n);
      strap.test_port_select <= 1'b1;
      strap.factory_test <= 1'b1;
      repeat (6) @(posedge clock);
      chk("scan_blocked", 1'b0, scan_mode);
      strap.factory_test <= 1'b0;
      repeat (6) @(posedge clock);
      chk("scan_mode", 1'b1, scan_mode);
      tms_seq(8'h00, 1);
      ir(BSM_IR_SAMPLE);
      chk("ir_capture", 32'h1, sv & 32'hF);
      dr('0);
      chk("sample_chain", cap(16'h5A3C, 16'hA5C3, 16'h0F0F) & 32'hFFFFF, sv & 32'hFFFFF);
      ir(BSM_IR_EXTEST);
      dr(cap(16'h96A5, 16'h96A5, 16'h0A80));
      chk("extest_out", 16'h96A5 & DRV, pin_out & DRV);
      chk("extest_oe_n", 16'(~((16'h0A80 & OIO) | BUFM)), pin_oe_n);
      ir(BSM_IR_AC_PULSE);
      repeat (6) @(posedge clock);
      ac = pin_out;
      tms_seq(8'h00, 1);
      repeat (6) @(posedge clock);
      chk("ac_toggle", 16'hC000, (pin_out ^ ac) & DRV);
      // Bypass is one flop: a captured zero first, then the sent bits one step late.
      ir(BSM_IR_BYPASS);
      dr(32'h000A5A5);
      chk("bypass", 32'h0014B4A, sv & 32'hFFFFF);
      summarize();
   end
endmodule  // testbench
